// ===== bench/bic_checker.sv
// Port checker for the bus idle cycle controller.
// Assumes it is bound onto bic_top and sees only its ports.
module bic_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Access port
  input wire logic [bic_pkg::AREA_W-1:0] acc_area,
  input wire logic acc_write,
  input wire logic acc_done,
  input wire logic acc_err,
  // Strobes
  input wire logic [bic_pkg::NUM_SPACES-1:0] mem_cs_n,
  input wire logic mem_rd_n,
  input wire logic mem_wr_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import bic_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && penable && !pready |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  property p_unmap; pready && pslverr |-> prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_rsv2; pready |-> prdata[31:30] == 2'h0; endproperty
  a_rsv2: assert property (p_rsv2) else $error("bits 31:30 set");
  property p_rsv1; pready |-> !prdata[27] && !prdata[24] && !prdata[21]; endproperty
  a_rsv1: assert property (p_rsv1) else $error("single reserved bit set");
  property p_kind; acc_done && !acc_err |-> mem_wr_n != $past(acc_write) && !mem_cs_n[$past(acc_area)]; endproperty
  a_kind: assert property (p_kind) else $error("wrong strobe or select");
  property p_err; acc_done |-> acc_err == ($past(acc_area) > 3'h5); endproperty
  a_err: assert property (p_err) else $error("area error flag");
  property p_len; acc_done && !acc_err |=> (mem_rd_n != mem_wr_n) ##1 (acc_done || (mem_rd_n && mem_wr_n)); endproperty
  a_len: assert property (p_len) else $error("access length");
  property p_idle; mem_rd_n && mem_wr_n |-> mem_cs_n == 6'h3f; endproperty
  a_idle: assert property (p_idle) else $error("select in idle");
  property p_one; mem_cs_n != 6'h3f |-> $onehot(~mem_cs_n) && (mem_rd_n != mem_wr_n); endproperty
  a_one: assert property (p_one) else $error("select not single");
  property p_ill; acc_done && acc_err |-> mem_cs_n == 6'h3f ##1 mem_cs_n == 6'h3f; endproperty
  a_ill: assert property (p_ill) else $error("refused access strobed");
  c_unmap: cover property (pready && pslverr);
  c_write: cover property (acc_done && !acc_err && !mem_wr_n);
  c_ill: cover property (acc_done && acc_err);
endmodule
bind bic_top bic_checker bic_checker_inst (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .acc_area(acc_area),
  .acc_write(acc_write),
  .acc_done(acc_done),
  .acc_err(acc_err),
  .mem_cs_n(mem_cs_n),
  .mem_rd_n(mem_rd_n),
  .mem_wr_n(mem_wr_n)
);

// ===== bench/bic_mem_model.sv
// Model of the external memories: measures idle cycles before each access.
// Assumes each access holds its strobes low for two cycles.
module bic_mem_model (
  // Clock
  input wire logic pclk,
  // Strobes
  input wire logic [bic_pkg::NUM_SPACES-1:0] mem_cs_n,
  input wire logic mem_rd_n,
  input wire logic mem_wr_n,
  // Idle cycles seen before the last access
  output logic [2:0] gap
);
  timeunit 1ns;
  timeprecision 1ns;
  import bic_pkg::*;
  logic [2:0] cnt = 3'h4;
  logic mid = 1'b0;
  always @(posedge pclk) begin
    if (mem_rd_n && mem_wr_n) begin
      if (cnt != 3'h7) cnt <= cnt + 3'h1;
      mid <= 1'b0;
    end else begin
      if (!mid) gap <= cnt;
      cnt <= 3'h0;
      mid <= !mid;
    end
  end
endmodule

// ===== bench/test_bus_idle_cycle_control.sv
// Testbench for the bus idle cycle controller.
// Assumes an APB master and a requester on pclk; gaps measured by the memory model.
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_bus_idle_cycle_control;
  timeunit 1ns;
  timeprecision 1ns;
  import bic_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, acc_valid = 0, acc_write = 0;
  logic [ADDR_W-1:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, acc_done, acc_err, er;
  logic [AREA_W-1:0] acc_area = 0;
  logic [NUM_SPACES-1:0] mem_cs_n;
  logic mem_rd_n, mem_wr_n;
  logic [2:0] gap;
  int n_mismatch = 0, check_count = 0;
  always #50 pclk = ~pclk;
  bic_top bic_top_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .acc_valid(acc_valid),
    .acc_area(acc_area),
    .acc_write(acc_write),
    .acc_done(acc_done),
    .acc_err(acc_err),
    .mem_cs_n(mem_cs_n),
    .mem_rd_n(mem_rd_n),
    .mem_wr_n(mem_wr_n)
  );
  bic_mem_model bic_mem_model_inst (
    .pclk(pclk),
    .mem_cs_n(mem_cs_n),
    .mem_rd_n(mem_rd_n),
    .mem_wr_n(mem_wr_n),
    .gap(gap)
  );
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin n_mismatch++; results; end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task acc(input logic [2:0] a, input logic w);
    int i;
    acc_valid <= 1;
    acc_area <= a;
    acc_write <= w;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (acc_done === 1'b1) break;
    end
    if (i == 20) begin n_mismatch++; results; end
    er = acc_err;
  endtask
  task s_reset;
    for (int k = 0; k < 6; k++) begin
      apb(0, ADDR_W'(4 * k), 0);
      `CHK("reset", 32'h36c00000, rd)
    end
    apb(0, 12'h018, 0);
    `CHK("unmapped", 1'b1, er)
    `CHK("unmapped_data", 32'h00000000, rd)
  endtask
  task s_mask;
    apb(1, 12'h004, 32'h24800000);
    apb(0, 12'h004, 0);
    `CHK("field_rw", 32'h24800000, rd)
  endtask
  task s_gap;
    for (int f = 0; f < 3; f++) begin
      for (int c = 0; c < 4; c++) begin
        apb(1, 12'h004, 32'(c) << (f == 0 ? IWW_LSB : f == 1 ? IWRWD_LSB : IWRWS_LSB));
        acc(3'h1, f == 0);
        acc(f == 1 ? 3'h2 : 3'h1, f != 0 || c % 2 == 1);
        acc_valid <= 0;
        @(posedge pclk);
        `CHK("gap", (c == 3 ? 3'h4 : 3'(c)), gap)
      end
    end
  endtask
  task s_ill;
    acc(3'h6, 0);
    `CHK("refuse6", 1'b1, er)
    acc(3'h7, 1);
    acc_valid <= 0;
    `CHK("refuse7", 1'b1, er)
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    s_reset;
    s_mask;
    s_gap;
    s_ill;
    results;
  end
endmodule

// ===== inc/bic_if.sv
// Interface between the access sequencer and the idle count decoder.
// Assumes both ends sit in the same clock domain.
interface bic_if;
  logic [1:0] iww;
  logic [1:0] iwrwd;
  logic [1:0] iwrws;
  logic prev_write;
  logic next_write;
  logic same_area;
  logic [2:0] need;
  modport ctrl (output iww, iwrwd, iwrws, prev_write, next_write, same_area, input need);
  modport calc (input iww, iwrwd, iwrws, prev_write, next_write, same_area, output need);
endinterface

// ===== inc/bic_pkg.sv
// Package for the bus idle cycle controller: register map, field layout, reset values, states.
// Assumes a 32-bit APB register bus and six chip-select spaces.
package bic_pkg;
  localparam int NUM_SPACES = 6;
  localparam int ADDR_W = 12;
  localparam int AREA_W = 3;
  localparam logic [AREA_W-1:0] LAST_AREA = 3'h5;
  // Byte offsets of the per-space bus control registers
  localparam logic [ADDR_W-1:0] SPACE_BASE = 12'h000;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 4;
  // Field positions
  localparam int FIELD_W = 2;
  localparam int IWW_LSB = 28;
  localparam int IWRWD_LSB = 25;
  localparam int IWRWS_LSB = 22;
  localparam logic [FIELD_W-1:0] FIELD_RESET = 2'h3;
  // Idle cycle codes and counts
  localparam logic [FIELD_W-1:0] CODE_NONE = 2'h0;
  localparam logic [FIELD_W-1:0] CODE_ONE = 2'h1;
  localparam logic [FIELD_W-1:0] CODE_TWO = 2'h2;
  localparam int GAP_W = 3;
  localparam logic [GAP_W-1:0] GAP_ZERO = 3'h0;
  localparam logic [GAP_W-1:0] GAP_ONE = 3'h1;
  localparam logic [GAP_W-1:0] GAP_TWO = 3'h2;
  localparam logic [GAP_W-1:0] GAP_MAX = 3'h4;
  typedef enum logic [3:0] {
    BIC_IDLE = 4'h1,
    BIC_ACC1 = 4'h2,
    BIC_ACC2 = 4'h4,
    BIC_ERR = 4'h8
  } bic_state_type;
endpackage

// ===== src/bic_idle_decode.sv
// Idle count decoder: turns the fields of the previous area into a required idle count.
// Assumes the sequencer presents the previous access and the pending request.
module bic_idle_decode (
  bic_if.calc dec
);
  import bic_pkg::*;

  function automatic logic [GAP_W-1:0] code_to_count(input logic [FIELD_W-1:0] code);
    unique case (code)
      CODE_NONE: code_to_count = GAP_ZERO;
      CODE_ONE: code_to_count = GAP_ONE;
      CODE_TWO: code_to_count = GAP_TWO;
      default: code_to_count = GAP_MAX;
    endcase
  endfunction

  function automatic logic [GAP_W-1:0] max_count(input logic [GAP_W-1:0] a, input logic [GAP_W-1:0] b);
    max_count = (a > b) ? a : b;
  endfunction

  logic [GAP_W-1:0] after_write;
  logic [GAP_W-1:0] after_read;

  always_comb begin
    after_write = code_to_count(dec.iww);
    if (!dec.next_write) begin
      after_read = GAP_ZERO;
    end else if (dec.same_area) begin
      after_read = code_to_count(dec.iwrws);
    end else begin
      after_read = code_to_count(dec.iwrwd);
    end
  end

  // Largest applicable count wins
  assign dec.need = max_count(dec.prev_write ? after_write : GAP_ZERO, dec.prev_write ? GAP_ZERO : after_read);
endmodule

// ===== src/bic_top.sv
// Bus idle cycle controller: per-space bus control registers on APB and an external access sequencer.
// Assumes the access requester runs on pclk and holds its request until acc_done.
module bic_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bic_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Access requests
  input wire logic acc_valid,
  input wire logic [bic_pkg::AREA_W-1:0] acc_area,
  input wire logic acc_write,
  output logic acc_done,
  output logic acc_err,
  // External memory strobes
  output logic [bic_pkg::NUM_SPACES-1:0] mem_cs_n,
  output logic mem_rd_n,
  output logic mem_wr_n
);
  import bic_pkg::*;

  function automatic logic [GAP_W-1:0] sat_inc(input logic [GAP_W-1:0] g);
    sat_inc = (g >= GAP_MAX) ? GAP_MAX : g + GAP_ONE;
  endfunction

  bic_if dec_if ();

  bic_idle_decode u_dec (
    .dec(dec_if)
  );

  // Register file state
  logic [FIELD_W-1:0] iww_reg [NUM_SPACES];
  logic [FIELD_W-1:0] iww_next [NUM_SPACES];
  logic [FIELD_W-1:0] iwrwd_reg [NUM_SPACES];
  logic [FIELD_W-1:0] iwrwd_next [NUM_SPACES];
  logic [FIELD_W-1:0] iwrws_reg [NUM_SPACES];
  logic [FIELD_W-1:0] iwrws_next [NUM_SPACES];
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [IDX_MSB-IDX_LSB:0] reg_idx;
  logic reg_hit;
  logic [31:0] read_word;

  // Sequencer state
  bic_state_type state_reg;
  bic_state_type state_next;
  logic [GAP_W-1:0] gap_reg;
  logic [GAP_W-1:0] gap_next;
  logic [GAP_W-1:0] idle_seen;
  logic [AREA_W-1:0] prev_area_reg;
  logic [AREA_W-1:0] prev_area_next;
  logic prev_write_reg;
  logic prev_write_next;
  logic done_reg;
  logic done_next;
  logic err_reg;
  logic err_next;
  logic [NUM_SPACES-1:0] cs_n_reg;
  logic [NUM_SPACES-1:0] cs_n_next;
  logic rd_n_reg;
  logic rd_n_next;
  logic wr_n_reg;
  logic wr_n_next;

  // Address decode: one aligned word per space
  assign reg_idx = paddr[IDX_MSB:IDX_LSB];
  assign reg_hit = (paddr[ADDR_W-1:IDX_MSB+1] == SPACE_BASE[ADDR_W-1:IDX_MSB+1]) && (paddr[1:0] == 2'h0) &&
                   (reg_idx <= LAST_AREA);

  always_comb begin
    read_word = 32'h0000_0000;
    if (reg_hit) begin
      read_word[IWW_LSB +: FIELD_W] = iww_reg[reg_idx];
      read_word[IWRWD_LSB +: FIELD_W] = iwrwd_reg[reg_idx];
      read_word[IWRWS_LSB +: FIELD_W] = iwrws_reg[reg_idx];
    end
  end

  // APB slave: one wait state, write takes effect at the completing edge
  always_comb begin
    pready_next = psel && penable && !pready_reg;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    iww_next = iww_reg;
    iwrwd_next = iwrwd_reg;
    iwrws_next = iwrws_reg;
    if (pready_next) begin
      pslverr_next = !reg_hit;
      prdata_next = pwrite ? 32'h0000_0000 : read_word;
    end
    if (psel && penable && pready_reg && pwrite && reg_hit) begin
      // Reserved bits are dropped on write
      iww_next[reg_idx] = pwdata[IWW_LSB +: FIELD_W];
      iwrwd_next[reg_idx] = pwdata[IWRWD_LSB +: FIELD_W];
      iwrws_next[reg_idx] = pwdata[IWRWS_LSB +: FIELD_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_SPACES; i++) begin
        iww_reg[i] <= FIELD_RESET;
        iwrwd_reg[i] <= FIELD_RESET;
        iwrws_reg[i] <= FIELD_RESET;
      end
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      iww_reg <= iww_next;
      iwrwd_reg <= iwrwd_next;
      iwrws_reg <= iwrws_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Decoder inputs: fields of the area last accessed
  assign dec_if.iww = iww_reg[prev_area_reg];
  assign dec_if.iwrwd = iwrwd_reg[prev_area_reg];
  assign dec_if.iwrws = iwrws_reg[prev_area_reg];
  assign dec_if.prev_write = prev_write_reg;
  assign dec_if.next_write = acc_write;
  assign dec_if.same_area = (acc_area == prev_area_reg);

  // Access sequencer: each access lasts two cycles, decisions are taken in idle or in the last access cycle
  always_comb begin
    state_next = BIC_IDLE;
    prev_area_next = prev_area_reg;
    prev_write_next = prev_write_reg;
    done_next = 1'b0;
    err_next = 1'b0;
    cs_n_next = '1;
    rd_n_next = 1'b1;
    wr_n_next = 1'b1;
    idle_seen = ((state_reg == BIC_ACC1) || (state_reg == BIC_ACC2)) ? GAP_ZERO : sat_inc(gap_reg);
    gap_next = idle_seen;
    unique case (state_reg)
      BIC_ACC1: begin
        // Hold select and strobe for the second access cycle
        state_next = BIC_ACC2;
        cs_n_next = cs_n_reg;
        rd_n_next = rd_n_reg;
        wr_n_next = wr_n_reg;
      end
      BIC_IDLE, BIC_ACC2: begin
        if (acc_valid && (acc_area > LAST_AREA)) begin
          state_next = BIC_ERR;
          done_next = 1'b1;
          err_next = 1'b1;
        end else if (acc_valid && (idle_seen >= dec_if.need)) begin
          state_next = BIC_ACC1;
          done_next = 1'b1;
          cs_n_next[acc_area] = 1'b0;
          rd_n_next = acc_write;
          wr_n_next = !acc_write;
          prev_area_next = acc_area;
          prev_write_next = acc_write;
        end
      end
      BIC_ERR: begin
        // One forced idle cycle after a refused request
        state_next = BIC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= BIC_IDLE;
      gap_reg <= GAP_MAX;
      prev_area_reg <= 3'h0;
      prev_write_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      cs_n_reg <= '1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      gap_reg <= gap_next;
      prev_area_reg <= prev_area_next;
      prev_write_reg <= prev_write_next;
      done_reg <= done_next;
      err_reg <= err_next;
      cs_n_reg <= cs_n_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign acc_done = done_reg;
  assign acc_err = err_reg;
  assign mem_cs_n = cs_n_reg;
  assign mem_rd_n = rd_n_reg;
  assign mem_wr_n = wr_n_reg;
endmodule
